// ==== hw/dmc_pkg.sv ====
// constants, types and register map of the decimation mode control block
// Function
// - Two independent channel modes, A and B, each hold their own decimation rate and filter type in a register.
// - Each converter channel takes decimation and filter from the mode that the mode select register assigns it.
// - Bit 3 of a channel mode register picks the filter: 0 wideband, 1 sinc5.
// - Decimation codes 000 to 100 give 32, 64, 128, 256, 512 and codes 101 to 111 all give 1024.
// - In pin control mode the decimation comes from the two decimation select pins, not the mode registers.
// - First data-ready rise follows the sync reference edge by 1487 to 33231 clock periods for decimation 32 to 1024.
// - First settled data-ready rise follows the sync reference edge by 6607 to 197071 clock periods.
// - With both groups active, first data-ready follows the faster group and each group settles on its own rate.
package dmc_pkg;

  localparam logic [7:0] OFF_MODE_A   = 8'h01;
  localparam logic [7:0] OFF_MODE_B   = 8'h02;
  localparam logic [7:0] OFF_MODE_SEL = 8'h03;

  localparam int         FILTER_BIT   = 3;
  localparam int         DEC_MSB      = 2;
  localparam logic [7:0] MODE_MASK    = 8'h0F;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [7:0] SEL_RST      = 8'h00;

  localparam int         RATIO_W      = 11;
  localparam logic [RATIO_W-1:0] RATIO_BASE = 11'h020;
  localparam logic [2:0] DEC_IDX_MAX  = 3'h5;

  localparam int         CNT_W        = 18;
  localparam int unsigned CYC_PER_PERIOD = 1;
  localparam int unsigned FIRST_PERIODS  [6] = '{1487, 2511, 4559, 8655, 16847, 33231};
  localparam int unsigned SETTLE_PERIODS [6] = '{6607, 12751, 25039, 49615, 98767, 197071};
  localparam int unsigned FIRST_CYC  [6] = '{FIRST_PERIODS[0]*CYC_PER_PERIOD, FIRST_PERIODS[1]*CYC_PER_PERIOD,
                                             FIRST_PERIODS[2]*CYC_PER_PERIOD, FIRST_PERIODS[3]*CYC_PER_PERIOD,
                                             FIRST_PERIODS[4]*CYC_PER_PERIOD, FIRST_PERIODS[5]*CYC_PER_PERIOD};
  localparam int unsigned SETTLE_CYC [6] = '{SETTLE_PERIODS[0]*CYC_PER_PERIOD, SETTLE_PERIODS[1]*CYC_PER_PERIOD,
                                             SETTLE_PERIODS[2]*CYC_PER_PERIOD, SETTLE_PERIODS[3]*CYC_PER_PERIOD,
                                             SETTLE_PERIODS[4]*CYC_PER_PERIOD, SETTLE_PERIODS[5]*CYC_PER_PERIOD};

  typedef enum logic {
    DMC_FLT_WIDEBAND = 1'b0,
    DMC_FLT_SINC5    = 1'b1
  } dmc_filter_t;

  typedef enum logic {
    DMC_IDLE = 1'b0,
    DMC_RUN  = 1'b1
  } dmc_state_t;

  typedef struct packed {
    dmc_filter_t          filter;
    logic [RATIO_W-1:0]   ratio;
  } dmc_ch_cfg_t;

endpackage

// ==== hw/dmc_decimation_mode_control.sv ====
// decimation mode registers, per-channel mode mapping and sync-to-data-ready latency
module dmc_decimation_mode_control #(
  parameter int          NUM_CH         = 8,
  parameter int unsigned FIRST_DLY  [6] = dmc_pkg::FIRST_CYC,
  parameter int unsigned SETTLE_DLY [6] = dmc_pkg::SETTLE_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rstn_i,
  input  wire logic [7:0]          reg_addr_i,
  input  wire logic [7:0]          reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output      logic [7:0]          reg_rdata_o,
  input  wire logic                pin_control_mode_i,
  input  wire logic                decimation_select_pin_low_i,
  input  wire logic                decimation_select_pin_high_i,
  input  wire logic                sync_i,
  output      dmc_pkg::dmc_ch_cfg_t ch_cfg_o [NUM_CH],
  output      logic                data_ready_strobe_o,
  output      logic                settled_a_o,
  output      logic                settled_b_o
);

  // code to table index: 101..111 all fold onto the 1024 entry
  function automatic logic [2:0] dec_idx(input logic [2:0] code);
    dec_idx = (code > dmc_pkg::DEC_IDX_MAX) ? dmc_pkg::DEC_IDX_MAX : code;
  endfunction

  function automatic logic [dmc_pkg::RATIO_W-1:0] dec_ratio(input logic [2:0] code);
    dec_ratio = dmc_pkg::RATIO_BASE << dec_idx(code);
  endfunction

  logic [7:0]            mode_a;
  logic [7:0]            mode_b;
  logic [7:0]            mode_sel;
  dmc_pkg::dmc_state_t   state;
  logic                  sync_q;
  logic [dmc_pkg::CNT_W-1:0] cnt;
  logic [dmc_pkg::CNT_W-1:0] first_tgt;
  logic [dmc_pkg::CNT_W-1:0] settle_a_tgt;
  logic [dmc_pkg::CNT_W-1:0] settle_b_tgt;
  logic                  act_a;
  logic                  act_b;

  // register access
  wire       wr_a   = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_MODE_A);
  wire       wr_b   = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_MODE_B);
  wire       wr_sel = reg_wr_i && (reg_addr_i == dmc_pkg::OFF_MODE_SEL);
  wire [7:0] wdata_mode = reg_wdata_i & dmc_pkg::MODE_MASK;
  wire [7:0] rd_mux =
    (reg_addr_i == dmc_pkg::OFF_MODE_A)   ? mode_a   :
    (reg_addr_i == dmc_pkg::OFF_MODE_B)   ? mode_b   :
    (reg_addr_i == dmc_pkg::OFF_MODE_SEL) ? mode_sel : 8'h00;

  // pin control overrides the decimation code of both modes
  wire [2:0] pin_code = {1'b0, decimation_select_pin_high_i, decimation_select_pin_low_i};
  wire [2:0] code_a   = pin_control_mode_i ? pin_code : mode_a[dmc_pkg::DEC_MSB:0];
  wire [2:0] code_b   = pin_control_mode_i ? pin_code : mode_b[dmc_pkg::DEC_MSB:0];

  // groups are active when at least one channel maps onto them
  wire [NUM_CH-1:0] sel_b    = mode_sel[NUM_CH-1:0];
  wire              use_a    = ~&sel_b;
  wire              use_b    = |sel_b;
  wire [2:0]        idx_a    = dec_idx(code_a);
  wire [2:0]        idx_b    = dec_idx(code_b);
  // first data-ready follows the faster active group
  wire [2:0]        idx_first = (use_a && (!use_b || idx_a <= idx_b)) ? idx_a : idx_b;
  wire              sync_rise = sync_i && !sync_q;
  wire [dmc_pkg::CNT_W-1:0] last_tgt = (settle_a_tgt > settle_b_tgt) ? settle_a_tgt : settle_b_tgt;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mode_a      <= dmc_pkg::MODE_RST;
      mode_b      <= dmc_pkg::MODE_RST;
      mode_sel    <= dmc_pkg::SEL_RST;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      if (wr_a)
        mode_a <= wdata_mode;
      if (wr_b)
        mode_b <= wdata_mode;
      if (wr_sel)
        mode_sel <= reg_wdata_i;
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
    end
  end

  // per-channel configuration, registered so each output is a flop
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++)
    begin : g_ch
      wire [7:0] mode_reg = sel_b[gi] ? mode_b : mode_a;
      wire [2:0] code     = sel_b[gi] ? code_b : code_a;
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          ch_cfg_o[gi] <= '{filter: dmc_pkg::DMC_FLT_WIDEBAND, ratio: dmc_pkg::RATIO_BASE};
        else
          ch_cfg_o[gi] <= '{filter: dmc_pkg::dmc_filter_t'(mode_reg[dmc_pkg::FILTER_BIT]),
                            ratio:  dec_ratio(code)};
      end
    end
  endgenerate

  // latency sequencer: targets latched on the sync reference edge so later writes do not disturb it
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state               <= dmc_pkg::DMC_IDLE;
      sync_q              <= 1'b0;
      cnt                 <= '0;
      first_tgt           <= '0;
      settle_a_tgt        <= '0;
      settle_b_tgt        <= '0;
      act_a               <= 1'b0;
      act_b               <= 1'b0;
      data_ready_strobe_o <= 1'b0;
      settled_a_o         <= 1'b0;
      settled_b_o         <= 1'b0;
    end
    else
    begin
      sync_q <= sync_i;
      case (state)
        dmc_pkg::DMC_IDLE:
        begin
          data_ready_strobe_o <= 1'b0;
          settled_a_o         <= 1'b0;
          settled_b_o         <= 1'b0;
          if (sync_rise)
          begin
            state        <= dmc_pkg::DMC_RUN;
            cnt          <= dmc_pkg::CNT_W'(1);
            first_tgt    <= dmc_pkg::CNT_W'(FIRST_DLY[idx_first]);
            settle_a_tgt <= dmc_pkg::CNT_W'(SETTLE_DLY[idx_a]);
            settle_b_tgt <= dmc_pkg::CNT_W'(SETTLE_DLY[idx_b]);
            act_a        <= use_a;
            act_b        <= use_b;
          end
        end
        dmc_pkg::DMC_RUN:
        begin
          // a new sync edge abandons the measurement and returns to idle
          if (sync_rise)
            state <= dmc_pkg::DMC_IDLE;
          else if (cnt >= last_tgt)
            state <= dmc_pkg::DMC_IDLE;
          cnt                 <= cnt + dmc_pkg::CNT_W'(1);
          data_ready_strobe_o <= (cnt == first_tgt);
          settled_a_o         <= act_a && (cnt == settle_a_tgt);
          settled_b_o         <= act_b && (cnt == settle_b_tgt);
        end
        default:
          state <= dmc_pkg::DMC_IDLE;
      endcase
    end
  end

  // checks
  sequence s_sync_edge;
    sync_i && !sync_q && state == dmc_pkg::DMC_IDLE;
  endsequence

  sequence s_run_started;
    state == dmc_pkg::DMC_RUN && cnt == dmc_pkg::CNT_W'(1);
  endsequence

  property p_mode_reserved;
    @(posedge clk_i) disable iff (!rstn_i)
      wr_a |=> mode_a[7:4] == 4'h0 && mode_a[3:0] == $past(reg_wdata_i[3:0]);
  endproperty
  a_mode_reserved: assert property (p_mode_reserved) else $error("mode A reserved bits or stored value wrong");

  property p_readback;
    @(posedge clk_i) disable iff (!rstn_i)
      reg_rd_i && reg_addr_i == dmc_pkg::OFF_MODE_B |=> reg_rdata_o == $past(mode_b);
  endproperty
  a_readback: assert property (p_readback) else $error("mode B readback wrong");

  function automatic dmc_pkg::dmc_filter_t dmc_filter_from(input logic b);
    dmc_filter_from = b ? dmc_pkg::DMC_FLT_SINC5 : dmc_pkg::DMC_FLT_WIDEBAND;
  endfunction

  property p_filter_map;
    @(posedge clk_i) disable iff (!rstn_i)
      !sel_b[0] |=> ch_cfg_o[0].filter == dmc_filter_from($past(mode_a[3]));
  endproperty
  a_filter_map: assert property (p_filter_map) else $error("channel 0 filter not taken from mode A");

  property p_ratio_fold;
    @(posedge clk_i) disable iff (!rstn_i)
      !pin_control_mode_i && sel_b[0] && mode_b[2:0] >= 3'h5 |=> ch_cfg_o[0].ratio == 11'h400;
  endproperty
  a_ratio_fold: assert property (p_ratio_fold) else $error("high decimation codes must give 1024");

  property p_ratio_reg;
    @(posedge clk_i) disable iff (!rstn_i)
      !pin_control_mode_i && !sel_b[0] && mode_a[2:0] == 3'h2 |=> ch_cfg_o[0].ratio == 11'h080;
  endproperty
  a_ratio_reg: assert property (p_ratio_reg) else $error("code 010 must give 128");

  property p_pin_mode;
    @(posedge clk_i) disable iff (!rstn_i)
      pin_control_mode_i && decimation_select_pin_high_i && !decimation_select_pin_low_i
      |=> ch_cfg_o[0].ratio == 11'h080;
  endproperty
  a_pin_mode: assert property (p_pin_mode) else $error("pin control decimation ignored");

  property p_start;
    @(posedge clk_i) disable iff (!rstn_i)
      s_sync_edge |=> s_run_started ##1 !data_ready_strobe_o;
  endproperty
  a_start: assert property (p_start) else $error("sync edge did not start latency count");

  property p_first_time;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(data_ready_strobe_o) |-> cnt == first_tgt + dmc_pkg::CNT_W'(1);
  endproperty
  a_first_time: assert property (p_first_time) else $error("first data-ready at wrong count");

  property p_settle_time;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(settled_a_o) |-> cnt == settle_a_tgt + dmc_pkg::CNT_W'(1) && act_a;
  endproperty
  a_settle_time: assert property (p_settle_time) else $error("group A settled at wrong count");

  property p_settle_b;
    @(posedge clk_i) disable iff (!rstn_i)
      $rose(settled_b_o) |-> cnt == settle_b_tgt + dmc_pkg::CNT_W'(1) && act_b && first_tgt < settle_b_tgt;
  endproperty
  a_settle_b: assert property (p_settle_b) else $error("group B settled at wrong count");

endmodule

// ==== testbench/dmc_host_model.sv ====
// host controller model that drives the register port of the mode control block
module dmc_host_model (
  input  wire logic       clk_i,
  output      logic [7:0] addr_o,
  output      logic [7:0] wdata_o,
  output      logic       wr_o,
  output      logic       rd_o,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // a spare edge first, so a strobe is never lowered and raised in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
  endtask

  // read data is registered on the read edge, so it is taken one half cycle later
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o   = 1'b0;
    d      = rdata_i;
  endtask
endmodule

// ==== testbench/dmc_testbench.sv ====
// self-checking bench for the decimation mode control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // short latency tables keep the run brief
  localparam int unsigned F_D [6] = '{10, 12, 14, 16, 18, 20};
  localparam int unsigned S_D [6] = '{30, 32, 34, 36, 38, 40};
  localparam logic [7:0] ROW_A [4] = '{8'h09, 8'h09, 8'h0E, 8'h09};
  localparam logic [7:0] ROW_B [4] = '{8'h08, 8'h08, 8'h08, 8'h08};
  localparam logic [7:0] ROW_S [4] = '{8'h00, 8'h02, 8'h00, 8'h03};
  localparam int         ROW_E [4][3] = '{'{12, 32, -1}, '{10, 32, 30}, '{20, 40, -1}, '{10, -1, 30}};

  logic                 clk_i = 1'b0;
  logic                 rstn_i = 1'b0;
  logic [7:0]           addr, wdata, rdata, rd_v;
  logic                 wr, rd, rdy, set_a, set_b;
  logic                 pin_mode = 1'b0;
  logic                 pin_lo = 1'b0;
  logic                 pin_hi = 1'b0;
  logic                 sync = 1'b0;
  dmc_pkg::dmc_ch_cfg_t cfg [2];
  int                   failures = 0;
  int                   total_checks = 0;
  int                   t_rdy, t_a, t_b;
  int                   n_rdy, n_a, n_b;

  always #2 clk_i = ~clk_i;

  dmc_host_model host_u (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  dmc_decimation_mode_control #(.NUM_CH(2), .FIRST_DLY(F_D), .SETTLE_DLY(S_D)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .pin_control_mode_i(pin_mode), .decimation_select_pin_low_i(pin_lo),
    .decimation_select_pin_high_i(pin_hi), .sync_i(sync), .ch_cfg_o(cfg), .data_ready_strobe_o(rdy),
    .settled_a_o(set_a), .settled_b_o(set_b));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] cfg_of(input logic f, input logic [2:0] c);
    return {4'h0, f, (c > 3'h4) ? 11'h400 : 11'h020 << c};
  endfunction

  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // first sighting and number of each strobe, counted in edges after the sync edge;
  // abort_at raises sync again, cut_at pulls reset for two edges in mid-count
  task automatic run_sync(input int abort_at, input int cut_at);
    t_rdy = -1;
    t_a   = -1;
    t_b   = -1;
    n_rdy = 0;
    n_a   = 0;
    n_b   = 0;
    @(negedge clk_i);
    sync  = 1'b1;
    for (int k = 0; k < 60; k++)
    begin
      @(negedge clk_i);
      sync   = (k == abort_at);
      rstn_i = (k < cut_at || k > cut_at + 1);
      if (rdy === 1'b1 && t_rdy < 0) t_rdy = k;
      if (set_a === 1'b1 && t_a < 0) t_a = k;
      if (set_b === 1'b1 && t_b < 0) t_b = k;
      n_rdy += int'(rdy === 1'b1);
      n_a   += int'(set_a === 1'b1);
      n_b   += int'(set_b === 1'b1);
    end
  endtask

  initial
  begin
    #100us;
    failures++;
    final_report();
  end

  initial
  begin
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    for (int a = 1; a < 5; a++)
    begin
      host_u.rd_reg(8'(a), rd_v);
      check(16'(rd_v), 16'h0000);
    end
    check(16'(cfg[0]), cfg_of(1'b0, 3'h0));
    for (int c = 0; c < 8; c++)
    begin
      host_u.wr_reg(8'h01, {4'hF, 1'(c), 3'(c)});
      host_u.rd_reg(8'h01, rd_v);
      check(16'(rd_v), {8'h00, 4'h0, 1'(c), 3'(c)});
      check(16'(cfg[0]), cfg_of(1'(c), 3'(c)));
    end
    host_u.wr_reg(8'h01, 8'h09);
    host_u.wr_reg(8'h02, 8'h03);
    host_u.wr_reg(8'h03, 8'h02);
    host_u.rd_reg(8'h02, rd_v);
    check(16'(rd_v), 16'h0003);
    check(16'(cfg[0]), cfg_of(1'b1, 3'h1));
    check(16'(cfg[1]), cfg_of(1'b0, 3'h3));
    host_u.wr_reg(8'h03, 8'h01);
    host_u.wr_reg(8'h04, 8'hFF);
    host_u.rd_reg(8'h03, rd_v);
    check(16'(rd_v), 16'h0001);
    check(16'(cfg[0]), cfg_of(1'b0, 3'h3));
    check(16'(cfg[1]), cfg_of(1'b1, 3'h1));
    host_u.wr_reg(8'h02, 8'h07);
    host_u.rd_reg(8'h02, rd_v);
    check(16'(rd_v), 16'h0007);
    check(16'(cfg[0]), cfg_of(1'b0, 3'h7));
    pin_mode = 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      {pin_hi, pin_lo} = 2'(p);
      repeat (2) @(negedge clk_i);
      check(16'(cfg[0]), cfg_of(1'b0, 3'(p)));
      check(16'(cfg[1]), cfg_of(1'b1, 3'(p)));
    end
    pin_mode = 1'b0;
    for (int r = 0; r < 4; r++)
    begin
      host_u.wr_reg(8'h01, ROW_A[r]);
      host_u.wr_reg(8'h02, ROW_B[r]);
      host_u.wr_reg(8'h03, ROW_S[r]);
      repeat (2) @(negedge clk_i);
      run_sync(99, 99);
      check(16'(t_rdy), 16'(ROW_E[r][0]));
      check(16'(t_a), 16'(ROW_E[r][1]));
      check(16'(t_b), 16'(ROW_E[r][2]));
      check(16'(n_rdy), 16'h0001);
      check(16'(n_a), 16'(ROW_E[r][1] >= 0));
      check(16'(n_b), 16'(ROW_E[r][2] >= 0));
    end
    // a second sync rise while counting abandons the measurement
    run_sync(3, 99);
    check(16'(n_rdy + n_a + n_b), 16'h0000);
    run_sync(99, 99);
    check(16'(t_rdy), 16'(ROW_E[3][0]));
    check(16'(t_b), 16'(ROW_E[3][2]));
    // reset in mid-count drops the strobes and the register contents
    run_sync(99, 4);
    check(16'(n_rdy + n_a + n_b), 16'h0000);
    host_u.rd_reg(8'h01, rd_v);
    check(16'(rd_v), 16'h0000);
    check(16'(cfg[0]), cfg_of(1'b0, 3'h0));
    run_sync(99, 99);
    check(16'(t_rdy), 16'(F_D[0]));
    check(16'(t_a), 16'(S_D[0]));
    final_report();
  end
endmodule
